// ---- core/pcp_pkg.sv ----
// Shared constants for the pump, calibration and detector configuration block
package pcp_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 24;

  // Register offsets
  localparam logic [7:0] PUMP_GAIN_OFFSET_ADR = 8'h09;
  localparam logic [7:0] OSC_CAL_SETUP_ADR    = 8'h0a;
  localparam logic [7:0] DET_PUMP_CTRL_ADR    = 8'h0b;

  // Reset values
  localparam logic [23:0] PUMP_GAIN_OFFSET_RST = 24'h54_7264;
  localparam logic [23:0] OSC_CAL_SETUP_RST    = 24'h00_2046;
  localparam logic [23:0] DET_PUMP_CTRL_RST    = 24'h07_8061;

  // pump_gain_offset fields
  localparam int unsigned DN_GAIN_LSB  = 0;
  localparam int unsigned UP_GAIN_LSB  = 7;
  localparam int unsigned OFS_MAG_LSB  = 14;
  localparam int unsigned GAIN_W       = 7;
  localparam int unsigned OFS_UP_BIT   = 21;
  localparam int unsigned OFS_DN_BIT   = 22;
  localparam int unsigned HI_CUR_BIT   = 23;

  // oscillator_calibration_setup fields
  localparam int unsigned MEAS_LEN_LSB = 0;
  localparam int unsigned MEAS_LEN_W   = 3;
  localparam int unsigned CAL_OFF_BIT  = 11;
  localparam int unsigned CLK_SEL_LSB  = 13;
  localparam int unsigned CLK_SEL_W    = 2;
  localparam int unsigned RELOCK_BIT   = 17;

  // detector_pump_control fields
  localparam int unsigned POL_INV_BIT  = 4;
  localparam int unsigned UP_OE_BIT    = 5;
  localparam int unsigned DN_OE_BIT    = 6;
  localparam int unsigned FORCE_UP_BIT = 9;
  localparam int unsigned FORCE_DN_BIT = 10;
  localparam int unsigned FORCE_MID_BIT = 11;

  // Pump current scale, microamps
  localparam int unsigned CUR_W = 13;
  localparam logic [12:0] GAIN_STEP_UA = 13'h0014;
  localparam logic [12:0] OFS_STEP_UA  = 13'h0005;
  localparam logic [12:0] HI_CUR_UA    = 13'h0bb8;

  // Measurement length table, reference-divider cycles
  localparam int unsigned MEAS_CNT_W = 9;
  localparam logic [8:0] MEAS_LEN_TBL [8] = '{
    9'h001, 9'h002, 9'h004, 9'h008, 9'h020, 9'h040, 9'h080, 9'h100};

  // Calibration clock divider terminal counts for /1, /4, /16, /32
  localparam int unsigned DIV_W = 5;
  localparam logic [4:0] DIV_TC_TBL [4] = '{5'h00, 5'h03, 5'h0f, 5'h1f};

  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_WAIT,
    CAL_MEASURE,
    CAL_DONE
  } pcp_cal_state_e;
endpackage : pcp_pkg

// ---- core/pcp_config.sv ----
// Pump gain/offset, oscillator calibration sequencer and detector control bank
// Functional notes
// (R1) Down-pump gain: 7-bit code, 20 uA per code, 0 to 2.54 mA.
// (R2) Up-pump gain: 7-bit code, 20 uA per code, resets to 100.
// (R3) Pump offset magnitude: 5 uA per code, up to 635 uA, resets to 81.
// (R4) Upward offset enable applies the offset upward; clear gives none.
// (R5) Downward offset enable applies the offset downward; resets to 1.
// (R6) High-current mode adds 3 mA; only with external oscillator, active filter.
// (R7) Measurement lasts 1,2,4,8,32,64,128 or 256 reference-divider cycles by code.
// (R8) Software avoids code 1 while the reference divider is one.
// (R9) Software picks a code so a measurement exceeds four microseconds.
// (R10) Calibration runs when its disable bit is 0, skipped when 1.
// (R11) Sequencer clock is crystal reference divided by 1, 4, 16 or 32.
// (R12) Relock bit set: one relock try per lock failure; clear: none. Code tries on the first failure only, then not again until lock_ok.
// (R13) Phase-select bit inverts detector polarity; resets to 0.
// (R14) Detector up output driven only while its enable is set.
// (R15) Detector down output driven only while its enable is set.
// (R16) Force-up test holds pump up on unless also forced down.
// (R17) Force-down test holds pump down on unless also forced up.
// (R18) Mid-rail test forces mid rail only when neither force bit active.
// (R19) Software writes zero to the two reserved detector bits 8:7.
// (R20) Software writes other reserved fields back with their reset value.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ns
module pcp_config (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [23:0] wdata,
  input  wire logic        write,
  input  wire logic        read,
  output logic      [23:0] rdata,
  // Reference and lock events
  input  wire logic        xtal_ref_tick,
  input  wire logic        ref_div_tick,
  input  wire logic        cal_request,
  input  wire logic        lock_fail,
  input  wire logic        lock_ok,
  // Raw phase detector
  input  wire logic        detector_up_raw,
  input  wire logic        detector_dn_raw,
  // Pump controls
  output logic [6:0]       down_pump_gain,
  output logic [6:0]       up_pump_gain,
  output logic [12:0]      up_current_ua,
  output logic [12:0]      down_current_ua,
  output logic             high_current_pump_mode,
  output logic             pump_up,
  output logic             pump_dn,
  output logic             pump_mid,
  // Calibration status
  output logic             cal_clk_en,
  output logic             cal_busy,
  output logic             cal_measuring,
  output logic             cal_done,
  output logic             cal_skipped,
  output logic             relock_try
);

  logic [23:0] pump_gain_offset_q;
  logic [23:0] osc_cal_setup_q;
  logic [23:0] det_pump_ctrl_q;
  logic [23:0] rdata_q;

  // Scaled current from a 7-bit code
  function automatic logic [12:0] scale_ua(input logic [6:0] code,
                                           input logic [12:0] step);
    logic [12:0] wide;
    wide = {6'h00, code} * step;
    return wide;
  endfunction : scale_ua

  // Register writes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pump_gain_offset_q <= pcp_pkg::PUMP_GAIN_OFFSET_RST;
      osc_cal_setup_q    <= pcp_pkg::OSC_CAL_SETUP_RST;
      det_pump_ctrl_q    <= pcp_pkg::DET_PUMP_CTRL_RST;
    end else if (write) begin
      // Reserved bits are stored as written; software keeps them sane
      case (addr)
        pcp_pkg::PUMP_GAIN_OFFSET_ADR: pump_gain_offset_q <= wdata;
        pcp_pkg::OSC_CAL_SETUP_ADR:    osc_cal_setup_q    <= wdata;
        pcp_pkg::DET_PUMP_CTRL_ADR:    det_pump_ctrl_q    <= wdata;
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q <= 24'h00_0000;
    end else if (read) begin
      case (addr)
        pcp_pkg::PUMP_GAIN_OFFSET_ADR: rdata_q <= pump_gain_offset_q;
        pcp_pkg::OSC_CAL_SETUP_ADR:    rdata_q <= osc_cal_setup_q;
        pcp_pkg::DET_PUMP_CTRL_ADR:    rdata_q <= det_pump_ctrl_q;
        default:                       rdata_q <= 24'h00_0000;
      endcase
    end else begin
      rdata_q <= 24'h00_0000;
    end
  end
  assign rdata = rdata_q;

  // Field views
  logic [6:0] dn_gain, up_gain, ofs_mag;
  logic       ofs_up_en, ofs_dn_en, hi_cur;
  logic [2:0] meas_code;
  logic [1:0] calibration_clock_divider_select;
  logic       calibration_off, relock_en;
  logic       detector_polarity_invert, detector_up_output_enable, detector_down_output_enable;
  logic       pump_force_up_test, pump_force_down_test, pump_force_midpoint_test;

  assign dn_gain   = pump_gain_offset_q[pcp_pkg::DN_GAIN_LSB +: pcp_pkg::GAIN_W];
  assign up_gain   = pump_gain_offset_q[pcp_pkg::UP_GAIN_LSB +: pcp_pkg::GAIN_W];
  assign ofs_mag   = pump_gain_offset_q[pcp_pkg::OFS_MAG_LSB +: pcp_pkg::GAIN_W];
  assign ofs_up_en = pump_gain_offset_q[pcp_pkg::OFS_UP_BIT];
  assign ofs_dn_en = pump_gain_offset_q[pcp_pkg::OFS_DN_BIT];
  assign hi_cur    = pump_gain_offset_q[pcp_pkg::HI_CUR_BIT];
  assign meas_code = osc_cal_setup_q[pcp_pkg::MEAS_LEN_LSB +: pcp_pkg::MEAS_LEN_W];
  assign calibration_off = osc_cal_setup_q[pcp_pkg::CAL_OFF_BIT];
  assign calibration_clock_divider_select =
    osc_cal_setup_q[pcp_pkg::CLK_SEL_LSB +: pcp_pkg::CLK_SEL_W];
  assign relock_en = osc_cal_setup_q[pcp_pkg::RELOCK_BIT];
  assign detector_polarity_invert    = det_pump_ctrl_q[pcp_pkg::POL_INV_BIT];
  assign detector_up_output_enable   = det_pump_ctrl_q[pcp_pkg::UP_OE_BIT];
  assign detector_down_output_enable = det_pump_ctrl_q[pcp_pkg::DN_OE_BIT];
  assign pump_force_up_test          = det_pump_ctrl_q[pcp_pkg::FORCE_UP_BIT];
  assign pump_force_down_test        = det_pump_ctrl_q[pcp_pkg::FORCE_DN_BIT];
  assign pump_force_midpoint_test    = det_pump_ctrl_q[pcp_pkg::FORCE_MID_BIT];

  // Pump gain and current outputs
  logic [12:0] up_cur_d, dn_cur_d;

  always_comb begin
    up_cur_d = scale_ua(up_gain, pcp_pkg::GAIN_STEP_UA); // [R2]
    dn_cur_d = scale_ua(dn_gain, pcp_pkg::GAIN_STEP_UA); // [R1]
    if (ofs_up_en) begin
      up_cur_d = up_cur_d + scale_ua(ofs_mag, pcp_pkg::OFS_STEP_UA); // [R3] [R4]
    end
    if (ofs_dn_en) begin
      dn_cur_d = dn_cur_d + scale_ua(ofs_mag, pcp_pkg::OFS_STEP_UA); // [R3] [R5]
    end
    if (hi_cur) begin
      up_cur_d = up_cur_d + pcp_pkg::HI_CUR_UA; // [R6]
      dn_cur_d = dn_cur_d + pcp_pkg::HI_CUR_UA; // [R6]
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      down_pump_gain         <= pcp_pkg::PUMP_GAIN_OFFSET_RST[6:0];
      up_pump_gain           <= pcp_pkg::PUMP_GAIN_OFFSET_RST[13:7];
      up_current_ua          <= 13'h0000;
      down_current_ua        <= 13'h0000;
      high_current_pump_mode <= 1'b0;
    end else begin
      down_pump_gain         <= dn_gain; // [R1]
      up_pump_gain           <= up_gain; // [R2]
      up_current_ua          <= up_cur_d;
      down_current_ua        <= dn_cur_d;
      high_current_pump_mode <= hi_cur; // [R6]
    end
  end

  // Detector path: polarity, enables, then test forcing
  logic up_sel, dn_sel;
  logic force_up_only, force_dn_only, force_mid;

  assign up_sel = detector_polarity_invert ? detector_dn_raw : detector_up_raw; // [R13]
  assign dn_sel = detector_polarity_invert ? detector_up_raw : detector_dn_raw; // [R13]
  assign force_up_only = pump_force_up_test & ~pump_force_down_test; // [R16]
  assign force_dn_only = pump_force_down_test & ~pump_force_up_test; // [R17]
  assign force_mid = pump_force_midpoint_test & ~pump_force_up_test
                     & ~pump_force_down_test; // [R18]

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pump_up  <= 1'b0;
      pump_dn  <= 1'b0;
      pump_mid <= 1'b0;
    end else begin
      pump_up  <= force_up_only
                  | (~force_dn_only & ~force_mid
                     & detector_up_output_enable & up_sel); // [R14] [R16]
      pump_dn  <= force_dn_only
                  | (~force_up_only & ~force_mid
                     & detector_down_output_enable & dn_sel); // [R15] [R17]
      pump_mid <= force_mid; // [R18]
    end
  end

  // Sequencer clock enable from the crystal reference
  logic [4:0] div_cnt_q;
  logic [4:0] div_tc;
  logic       fsm_tick_q;

  assign div_tc = pcp_pkg::DIV_TC_TBL[calibration_clock_divider_select];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_cnt_q  <= 5'h00;
      fsm_tick_q <= 1'b0;
    end else if (xtal_ref_tick) begin
      // A select change mid-count lengthens or shortens only one period
      if (div_cnt_q >= div_tc) begin
        div_cnt_q  <= 5'h00;
        fsm_tick_q <= 1'b1; // [R11]
      end else begin
        div_cnt_q  <= div_cnt_q + 5'h01;
        fsm_tick_q <= 1'b0;
      end
    end else begin
      fsm_tick_q <= 1'b0;
    end
  end
  assign cal_clk_en = fsm_tick_q;

  // Calibration sequencer
  pcp_pkg::pcp_cal_state_e st_q;
  logic [8:0] meas_cnt_q;
  logic [8:0] meas_target;
  logic       start_pend_q, rdiv_pend_q, relock_used_q;
  logic       take_start, take_rdiv, relock_go;

  assign meas_target = pcp_pkg::MEAS_LEN_TBL[meas_code];
  assign take_start = fsm_tick_q & (st_q == pcp_pkg::CAL_IDLE) & start_pend_q;
  assign take_rdiv = fsm_tick_q & rdiv_pend_q
                     & ((st_q == pcp_pkg::CAL_WAIT) | (st_q == pcp_pkg::CAL_MEASURE));
  assign relock_go = lock_fail & relock_en & ~relock_used_q; // [R12]

  // Pending flags: a new event beats a same-cycle consume
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      start_pend_q <= 1'b0;
      rdiv_pend_q  <= 1'b0;
    end else begin
      start_pend_q <= cal_request | relock_go | (start_pend_q & ~take_start);
      rdiv_pend_q  <= ref_div_tick | (rdiv_pend_q & ~take_rdiv);
    end
  end

  // One relock per loss; rearmed once lock is seen again
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      relock_used_q <= 1'b0;
      relock_try    <= 1'b0;
    end else begin
      relock_try <= relock_go; // [R12]
      if (relock_go) begin
        relock_used_q <= 1'b1; // [R12]
      end else if (lock_ok) begin
        relock_used_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q        <= pcp_pkg::CAL_IDLE;
      meas_cnt_q  <= 9'h000;
      cal_done    <= 1'b0;
      cal_skipped <= 1'b0;
    end else begin
      cal_done    <= 1'b0;
      cal_skipped <= 1'b0;
      if (fsm_tick_q) begin
        case (st_q)
          pcp_pkg::CAL_IDLE: begin
            if (take_start) begin
              if (calibration_off) begin
                cal_skipped <= 1'b1; // [R10]
              end else begin
                st_q <= pcp_pkg::CAL_WAIT; // [R10]
              end
            end
          end
          // First divider edge only aligns the window
          pcp_pkg::CAL_WAIT: begin
            if (take_rdiv) begin
              st_q       <= pcp_pkg::CAL_MEASURE;
              meas_cnt_q <= 9'h000;
            end
          end
          pcp_pkg::CAL_MEASURE: begin
            if (take_rdiv) begin
              if (meas_cnt_q + 9'h001 >= meas_target) begin
                st_q <= pcp_pkg::CAL_DONE; // [R7]
              end
              meas_cnt_q <= meas_cnt_q + 9'h001; // [R7]
            end
          end
          pcp_pkg::CAL_DONE: begin
            st_q     <= pcp_pkg::CAL_IDLE;
            cal_done <= 1'b1;
          end
          default: st_q <= pcp_pkg::CAL_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cal_busy      <= 1'b0;
      cal_measuring <= 1'b0;
    end else begin
      cal_busy      <= (st_q != pcp_pkg::CAL_IDLE);
      cal_measuring <= (st_q == pcp_pkg::CAL_MEASURE);
    end
  end

  // Checks
  sequence s_force_up;
    pump_force_up_test && !pump_force_down_test;
  endsequence
  sequence s_force_dn;
    pump_force_down_test && !pump_force_up_test;
  endsequence
  sequence s_measure_end;
    (st_q == pcp_pkg::CAL_MEASURE) ##1 (st_q == pcp_pkg::CAL_DONE);
  endsequence
  AST_FORCE_UP: assert property (@(posedge clk) disable iff (reset) // [R16]
    s_force_up |=> pump_up && !pump_dn && !pump_mid)
    else $error("forced up not seen on pump up");
  AST_FORCE_DN: assert property (@(posedge clk) disable iff (reset) // [R17]
    s_force_dn |=> pump_dn && !pump_up && !pump_mid)
    else $error("forced down not seen on pump down");
  AST_MID_RAIL: assert property (@(posedge clk) disable iff (reset) // [R18]
    pump_mid |-> $past(pump_force_midpoint_test) && !$past(pump_force_up_test)
                 && !$past(pump_force_down_test))
    else $error("mid rail while a force bit is active");
  AST_UP_GATE: assert property (@(posedge clk) disable iff (reset) // [R14]
    !detector_up_output_enable && !pump_force_up_test |=> !pump_up)
    else $error("pump up driven while disabled");
  AST_DN_GATE: assert property (@(posedge clk) disable iff (reset) // [R15]
    !detector_down_output_enable && !pump_force_down_test |=> !pump_dn)
    else $error("pump down driven while disabled");
  AST_POLARITY: assert property (@(posedge clk) disable iff (reset) // [R13]
    detector_polarity_invert && detector_up_output_enable
    && !pump_force_up_test && !pump_force_down_test && !pump_force_midpoint_test
    |=> pump_up == $past(detector_dn_raw))
    else $error("inverted polarity not applied");
  AST_CAL_OFF: assert property (@(posedge clk) disable iff (reset) // [R10]
    calibration_off && st_q == pcp_pkg::CAL_IDLE |=> st_q == pcp_pkg::CAL_IDLE)
    else $error("calibration ran while disabled");
  AST_MEAS_LEN: assert property (@(posedge clk) disable iff (reset) // [R7]
    s_measure_end |-> meas_cnt_q == $past(meas_target))
    else $error("measurement length differs from code");
  AST_RELOCK_ONCE: assert property (@(posedge clk) disable iff (reset) // [R12]
    relock_try |=> !relock_try [*2])
    else $error("second relock try without lock regained");
  AST_HI_CUR: assert property (@(posedge clk) disable iff (reset) // [R6]
    hi_cur ##1 hi_cur |-> up_current_ua >= pcp_pkg::HI_CUR_UA)
    else $error("high current mode did not add current");
  AST_DIV_TICK: assert property (@(posedge clk) disable iff (reset) // [R11]
    fsm_tick_q |-> $past(xtal_ref_tick))
    else $error("sequencer tick without reference edge");

endmodule : pcp_config

// ---- test/pcp_config_tb.sv ----
// Self-checking bench for the pump, calibration and detector configuration block
`timescale 1ns/1ns
module pcp_config_tb;
  logic        clk;
  logic        reset;
  logic [7:0]  addr;
  logic [23:0] wdata;
  logic        write;
  logic        read;
  logic [23:0] rdata;
  logic        xtal_ref_tick;
  logic        ref_div_tick;
  logic        cal_request;
  logic        lock_fail;
  logic        lock_ok;
  logic        detector_up_raw;
  logic        detector_dn_raw;
  logic [6:0]  down_pump_gain;
  logic [6:0]  up_pump_gain;
  logic [12:0] up_current_ua;
  logic [12:0] down_current_ua;
  logic        high_current_pump_mode;
  logic        pump_up;
  logic        pump_dn;
  logic        pump_mid;
  logic        cal_clk_en;
  logic        cal_busy;
  logic        cal_measuring;
  logic        cal_done;
  logic        cal_skipped;
  logic        relock_try;
  int          n_fail;
  int          compares;
  int          cyc;
  logic [23:0] rd_v;
  logic [23:0] wv [4] = '{24'hff_ffff, 24'h00_0000, 24'h20_3f81, 24'hd5_5555};
  int          n;
  int          nb;

  pcp_config dut (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .write(write), .read(read),
    .rdata(rdata), .xtal_ref_tick(xtal_ref_tick), .ref_div_tick(ref_div_tick),
    .cal_request(cal_request), .lock_fail(lock_fail), .lock_ok(lock_ok),
    .detector_up_raw(detector_up_raw), .detector_dn_raw(detector_dn_raw),
    .down_pump_gain(down_pump_gain), .up_pump_gain(up_pump_gain),
    .up_current_ua(up_current_ua), .down_current_ua(down_current_ua),
    .high_current_pump_mode(high_current_pump_mode), .pump_up(pump_up),
    .pump_dn(pump_dn), .pump_mid(pump_mid), .cal_clk_en(cal_clk_en),
    .cal_busy(cal_busy), .cal_measuring(cal_measuring), .cal_done(cal_done),
    .cal_skipped(cal_skipped), .relock_try(relock_try)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  // Ceiling well above the roughly one thousand cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      $display("CHECK FAILED timeout expected 0 seen %0d", cyc);
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic chk_n(input string nm, input int exp, input int got);
    compares++;
    if (got != exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : chk_n

  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    write <= 1'b1;
    @(posedge clk);
    write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [23:0] d);
    @(posedge clk);
    addr <= a;
    read <= 1'b1;
    @(posedge clk);
    read <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic wait_cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : wait_cyc

  function automatic logic [12:0] cur(input logic [6:0] g, input logic [6:0] o,
                                      input logic en, input logic hi);
    cur = 13'(g) * pcp_pkg::GAIN_STEP_UA + (en ? 13'(o) * pcp_pkg::OFS_STEP_UA : 13'h0000)
        + (hi ? pcp_pkg::HI_CUR_UA : 13'h0000);
  endfunction : cur

  // Detector case: register bits, raw levels, expected pump levels
  task automatic det(input logic [23:0] v, input logic ru, input logic rn, input logic eu,
                     input logic ed, input logic em, input logic ud);
    wr(pcp_pkg::DET_PUMP_CTRL_ADR, v);
    @(posedge clk);
    detector_up_raw <= ru;
    detector_dn_raw <= rn;
    wait_cyc(3);
    if (ud) begin
      chk("pump_up", {23'h0, eu}, {23'h0, pump_up});
      chk("pump_dn", {23'h0, ed}, {23'h0, pump_dn});
    end
    chk("pump_mid", {23'h0, em}, {23'h0, pump_mid});
  endtask : det

  // Pulses lock_fail and counts relock attempts that follow
  task automatic fail_pulse(input int exp);
    int k;
    k = 0;
    @(posedge clk);
    lock_fail <= 1'b1;
    @(posedge clk);
    lock_fail <= 1'b0;
    // The try pulse stands in the cycle right after this edge
    repeat (12) begin
      #1 if (relock_try === 1'b1) k++;
      @(posedge clk);
    end
    chk_n("relock_try count", exp, k);
  endtask : fail_pulse

  initial begin
    reset = 1'b1;
    addr = 8'h00;
    wdata = 24'h00_0000;
    write = 1'b0;
    read = 1'b0;
    xtal_ref_tick = 1'b1;
    ref_div_tick = 1'b1;
    cal_request = 1'b0;
    lock_fail = 1'b0;
    lock_ok = 1'b0;
    detector_up_raw = 1'b0;
    detector_dn_raw = 1'b0;
    n_fail = 0;
    compares = 0;
    cyc = 0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    wait_cyc(2);

    chk("up_current_ua", 24'(cur(7'd100, 7'd81, 1'b0, 1'b0)), 24'(up_current_ua));
    chk("down_current_ua", 24'(cur(7'd100, 7'd81, 1'b1, 1'b0)),
        24'(down_current_ua));
    rd(pcp_pkg::PUMP_GAIN_OFFSET_ADR, rd_v);
    chk("pump_gain_offset reset", 24'h54_7264, rd_v);
    rd(pcp_pkg::OSC_CAL_SETUP_ADR, rd_v);
    chk("oscillator_calibration_setup reset", 24'h00_2046, rd_v);
    rd(pcp_pkg::DET_PUMP_CTRL_ADR, rd_v);
    chk("detector_pump_control reset", 24'h07_8061, rd_v);
    rd(8'h0c, rd_v);
    chk("unmapped read", 24'h00_0000, rd_v);
    $display("Test reset values done");

    for (int i = 0; i < 4; i++) begin
      wr(pcp_pkg::PUMP_GAIN_OFFSET_ADR, wv[i]);
      rd(pcp_pkg::PUMP_GAIN_OFFSET_ADR, rd_v);
      chk("pump_gain_offset readback", wv[i], rd_v);
      wait_cyc(2);
      chk("down_pump_gain", 24'(wv[i][6:0]), 24'(down_pump_gain));
      chk("up_pump_gain", 24'(wv[i][13:7]), 24'(up_pump_gain));
      chk("up_current_ua", 24'(cur(wv[i][13:7], wv[i][20:14], wv[i][21], wv[i][23])),
          24'(up_current_ua));
      chk("down_current_ua", 24'(cur(wv[i][6:0], wv[i][20:14], wv[i][22], wv[i][23])),
          24'(down_current_ua));
      chk("high_current_pump_mode", 24'(wv[i][23]), 24'(high_current_pump_mode));
    end
    $display("Test pump gain and offset done");

    det(24'h07_8061, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    det(24'h07_8061, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    det(24'h07_8001, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    det(24'h07_8071, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    det(24'h07_8261, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    det(24'h07_8461, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    det(24'h07_8e61, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    det(24'h07_8a61, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    det(24'h07_8861, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    $display("Test detector and forcing done");

    // Sequencer clock enable period follows the divider select
    for (int s = 0; s < 4; s++) begin
      wr(pcp_pkg::OSC_CAL_SETUP_ADR, (24'(s) << 13) | 24'h00_0040);
      wait_cyc(40);
      while (cal_clk_en !== 1'b1) wait_cyc(1);
      n = 0;
      do begin
        wait_cyc(1);
        n++;
      end while (cal_clk_en !== 1'b1 && n < 40);
      chk_n("cal_clk_en period", (s == 0) ? 1 : (4 << (2 * (s - 1))) >> (s == 3), n);
    end
    $display("Test calibration clock divider done");

    for (int c = 0; c < 8; c++) begin
      // Reference divider setting and real measurement time lie outside this block
      wr(pcp_pkg::OSC_CAL_SETUP_ADR, 24'(c) | 24'h00_0040);
      @(posedge clk);
      cal_request <= 1'b1;
      @(posedge clk);
      cal_request <= 1'b0;
      n = 0;
      nb = 0;
      for (int k = 0; k < 600 && cal_done !== 1'b1; k++) begin
        wait_cyc(1);
        if (cal_measuring === 1'b1) n++;
        if (cal_busy === 1'b1) nb++;
      end
      chk("cal_done", 24'h00_0001, 24'(cal_done));
      chk_n("measure cycles", int'(pcp_pkg::MEAS_LEN_TBL[c]), n);
      chk_n("busy cycles", int'(pcp_pkg::MEAS_LEN_TBL[c]) + 2, nb);
    end
    wr(pcp_pkg::OSC_CAL_SETUP_ADR, 24'h00_0840);
    @(posedge clk);
    cal_request <= 1'b1;
    @(posedge clk);
    cal_request <= 1'b0;
    n = 0;
    repeat (20) begin
      wait_cyc(1);
      if (cal_skipped === 1'b1) n++;
      if (cal_done === 1'b1) n += 10;
      if (cal_busy === 1'b1) n += 100;
    end
    chk_n("skip without run", 1, n);
    $display("Test calibration runs done");

    wr(pcp_pkg::OSC_CAL_SETUP_ADR, 24'h02_0840);
    fail_pulse(1);
    fail_pulse(0);
    @(posedge clk);
    lock_ok <= 1'b1;
    repeat (3) @(posedge clk);
    lock_ok <= 1'b0;
    fail_pulse(1);
    wr(pcp_pkg::OSC_CAL_SETUP_ADR, 24'h00_0840);
    @(posedge clk);
    lock_ok <= 1'b1;
    repeat (3) @(posedge clk);
    lock_ok <= 1'b0;
    fail_pulse(0);
    $display("Test relock done");
    final_report();
  end
endmodule : pcp_config_tb
